// ===== common/uac_cfg.svh
`ifndef UAC_CFG_SVH
`define UAC_CFG_SVH

// Register byte offsets
`define UAC_OFF_CMD 16'h0010
`define UAC_OFF_STS 16'h0100
`define UAC_OFF_ERRTYPE 16'h0104
`define UAC_OFF_EXP 16'h0130
`define UAC_OFF_RDPAT 16'h0150
`define UAC_OFF_FAILL 16'h0170
`define UAC_OFF_FAILH 16'h0174
`define UAC_OFF_IRQSTS 16'h0180
`define UAC_OFF_IRQMSK 16'h0184
`define UAC_OFF_RAM 16'h4000
`define UAC_RAM_SPAN 16'h2000
`define UAC_OFF_SUBM 16'h6000
`define UAC_OFF_LINK 16'h8100

// Storage sizes
`define UAC_RAM_WORDS 128
`define UAC_RAM_IDX_W 7
`define UAC_SUBM_WORDS 16

// Command codes
`define UAC_CMD_SHUTDOWN 3'h1
`define UAC_CMD_SMART 3'h4
`define UAC_CMD_FLUSH 3'h6

// Status and interrupt bit positions
`define UAC_STS_BUSY 0
`define UAC_STS_ERR 1
`define UAC_STS_VFAIL 2
`define UAC_EV_DONE 0
`define UAC_EV_ERR 1
`define UAC_EV_VFAIL 2
`define UAC_EV_W 3

// Reset values
`define UAC_RST_WAITREQ 1'h1
`define UAC_RST_MASK 3'h0

`endif

// ===== common/uac_pkg.sv
`include "uac_cfg.svh"

package uac_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_RUN = 2'b10,
    ST_OFF = 2'b11
  } uac_state_t;

  typedef struct packed {
    logic req;
    logic [2:0] cmd;
  } uac_core_req_t;

  typedef struct packed {
    logic busy;
    logic error;
    logic [31:0] errType;
  } uac_core_rsp_t;

  typedef struct packed {
    logic en;
    logic [`UAC_RAM_IDX_W-1:0] idx;
    logic [31:0] data;
  } uac_ram_wr_t;

  typedef struct packed {
    logic valid;
    logic [56:0] addr;
    logic [3:0][31:0] expWords;
    logic [3:0][31:0] readWords;
  } uac_fail_t;

  typedef struct packed {
    uac_state_t state;
    uac_core_req_t coreReq;
    logic busy;
    logic err;
    logic [31:0] errCause;
    logic [`UAC_SUBM_WORDS-1:0][31:0] subm;
    logic [`UAC_RAM_WORDS-1:0][31:0] ram;
    logic [56:0] failAddr;
    logic [3:0][31:0] expWords;
    logic [3:0][31:0] readWords;
    logic [31:0] link;
    logic [`UAC_EV_W-1:0] irqSts;
    logic [`UAC_EV_W-1:0] irqMsk;
    logic irq;
    logic waitReq;
    logic [31:0] rdata;
  } uac_regs_t;

endpackage : uac_pkg

// ===== rtl/uac_top.sv
`timescale 1ns/1ps
`include "uac_cfg.svh"

// How it works
// (RULE1) Command value 100b on port 0 issues a health-log request from the entry.
// (RULE2) Command value 110b on port 0 issues a cache flush request from the entry.
// (RULE3) Command value 001b on port 0 issues an orderly shutdown request.
// (RULE4) Accepting a command raises busy, status bit 0.
// (RULE5) Busy returns low only once the command has finished.
// (RULE6) Any failure sets status bit 1 and latches a 32-bit cause word; the code keeps only the first cause of a command.
// (RULE7) Health-log data returned lands in the data RAM, readable by software.
// (RULE8) Software loads all sixteen entry words before a health-log or flush.
// (RULE9) Software polls status bits 1:0 until busy clears or error sets.
// (RULE10) After shutdown completes, no further command is accepted until power cycles.
// (RULE11) Software rereads the link status until two reads agree.
// (RULE12) First mismatch address, expected and read 128-bit words stay readable.
// (RULE13) Sixteen write-only entry words start at 0x6000.
// (RULE14) Data RAM window holds the 512-byte health-log payload.
// (RULE15) Command writes are ignored while busy.
module uac_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output uac_pkg::uac_core_req_t coreReq,
  output logic [`UAC_SUBM_WORDS-1:0][31:0] submEntry,
  input wire uac_pkg::uac_core_rsp_t coreRsp,
  input wire uac_pkg::uac_ram_wr_t ramWr,
  input wire uac_pkg::uac_fail_t verifyFail,
  input wire logic [31:0] linkStatus,
  output logic irq
);

  uac_pkg::uac_regs_t s_q;
  uac_pkg::uac_regs_t s_d;

  function automatic logic [31:0] beMerge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction : beMerge

  function automatic logic inRange(
    input logic [15:0] addr,
    input logic [15:0] base,
    input logic [15:0] span
  );
    return (addr >= base) && (addr < base + span);
  endfunction : inRange

  logic wrDone;
  logic rdTake;
  logic cmdWr;
  logic cmdOk;
  logic [`UAC_EV_W-1:0] events;
  logic [`UAC_RAM_IDX_W-1:0] ramIdx;
  logic [3:0] submIdx;
  logic [1:0] patIdx;

  // Write lands on the edge where waitrequest is seen low
  assign wrDone = avs_write && !s_q.waitReq;
  assign rdTake = avs_read && s_q.waitReq;
  assign cmdWr = wrDone && (avs_address == `UAC_OFF_CMD) && avs_byteenable[0];
  assign cmdOk = (avs_writedata[2:0] == `UAC_CMD_SMART) ||
                 (avs_writedata[2:0] == `UAC_CMD_FLUSH) ||
                 (avs_writedata[2:0] == `UAC_CMD_SHUTDOWN);
  assign ramIdx = avs_address[`UAC_RAM_IDX_W+1:2];
  assign submIdx = avs_address[5:2];
  assign patIdx = avs_address[3:2];

  always_comb begin
    s_d = s_q;
    events = '0;
    s_d.link = linkStatus;

    // Two-cycle bus answer: first edge sees the request, second completes it
    if (!s_q.waitReq) begin
      s_d.waitReq = 1'b1;
    end else if (avs_read || avs_write) begin
      s_d.waitReq = 1'b0;
    end

    if (rdTake) begin
      s_d.rdata = 32'h0000_0000;
      if (avs_address == `UAC_OFF_CMD) begin
        s_d.rdata = {29'h0000_0000, s_q.coreReq.cmd};
      end else if (avs_address == `UAC_OFF_STS) begin
        s_d.rdata = {29'h0000_0000, s_q.irqSts[`UAC_EV_VFAIL], s_q.err, s_q.busy}; // RULE9
      end else if (avs_address == `UAC_OFF_ERRTYPE) begin
        s_d.rdata = s_q.errCause; // RULE6
      end else if (inRange(avs_address, `UAC_OFF_EXP, 16'h0010)) begin
        s_d.rdata = s_q.expWords[patIdx]; // RULE12
      end else if (inRange(avs_address, `UAC_OFF_RDPAT, 16'h0010)) begin
        s_d.rdata = s_q.readWords[patIdx]; // RULE12
      end else if (avs_address == `UAC_OFF_FAILL) begin
        s_d.rdata = s_q.failAddr[31:0]; // RULE12
      end else if (avs_address == `UAC_OFF_FAILH) begin
        s_d.rdata = {7'h00, s_q.failAddr[56:32]};
      end else if (avs_address == `UAC_OFF_IRQSTS) begin
        s_d.rdata = {29'h0000_0000, s_q.irqSts};
      end else if (avs_address == `UAC_OFF_IRQMSK) begin
        s_d.rdata = {29'h0000_0000, s_q.irqMsk};
      end else if (inRange(avs_address, `UAC_OFF_RAM, 16'h0200)) begin
        s_d.rdata = s_q.ram[ramIdx]; // RULE7
      end else if (avs_address == `UAC_OFF_LINK) begin
        s_d.rdata = s_q.link; // RULE11
      end
    end

    // Register writes; entry words are write-only and read back as zero
    if (wrDone) begin
      if (inRange(avs_address, `UAC_OFF_SUBM, 16'h0040)) begin
        s_d.subm[submIdx] = beMerge(s_q.subm[submIdx], avs_writedata, avs_byteenable); // RULE13
      end else if (inRange(avs_address, `UAC_OFF_RAM, 16'h0200)) begin
        s_d.ram[ramIdx] = beMerge(s_q.ram[ramIdx], avs_writedata, avs_byteenable); // RULE14
      end else if (avs_address == `UAC_OFF_IRQMSK) begin
        s_d.irqMsk = avs_writedata[`UAC_EV_W-1:0];
      end
    end

    // Returned payload wins over a software write to the same word
    if (ramWr.en) begin
      s_d.ram[ramWr.idx] = ramWr.data; // RULE7
    end

    // First mismatch only; capture rearms once its flag is cleared
    if (verifyFail.valid && !s_q.irqSts[`UAC_EV_VFAIL]) begin
      s_d.failAddr = verifyFail.addr; // RULE12
      s_d.expWords = verifyFail.expWords;
      s_d.readWords = verifyFail.readWords;
    end
    events[`UAC_EV_VFAIL] = verifyFail.valid;

    case (s_q.state)
      uac_pkg::ST_IDLE: begin
        // Busy gates the command field; unknown codes are dropped
        if (cmdWr && cmdOk) begin // RULE15
          s_d.coreReq.req = 1'b1; // RULE1 RULE2 RULE3
          s_d.coreReq.cmd = avs_writedata[2:0];
          s_d.busy = 1'b1; // RULE4
          s_d.err = 1'b0;
          s_d.state = uac_pkg::ST_ISSUE;
        end
      end
      uac_pkg::ST_ISSUE: begin
        // Request held until the core shows it has taken it
        if (coreRsp.error) begin
          s_d.coreReq.req = 1'b0;
          s_d.err = 1'b1; // RULE6
          s_d.errCause = coreRsp.errType;
          s_d.busy = 1'b0;
          events[`UAC_EV_ERR] = 1'b1;
          s_d.state = uac_pkg::ST_IDLE;
        end else if (coreRsp.busy) begin
          s_d.coreReq.req = 1'b0;
          s_d.state = uac_pkg::ST_RUN;
        end
      end
      uac_pkg::ST_RUN: begin
        if (coreRsp.error && !s_q.err) begin
          s_d.err = 1'b1; // RULE6
          s_d.errCause = coreRsp.errType;
          events[`UAC_EV_ERR] = 1'b1;
        end
        if (!coreRsp.busy) begin
          s_d.busy = 1'b0; // RULE5
          events[`UAC_EV_DONE] = 1'b1;
          if (s_q.coreReq.cmd == `UAC_CMD_SHUTDOWN && !s_d.err) begin
            s_d.state = uac_pkg::ST_OFF; // RULE10
          end else begin
            s_d.state = uac_pkg::ST_IDLE;
          end
        end
      end
      uac_pkg::ST_OFF: begin
        // Drive is parked; only a reset (rst_n low) leaves this state
        s_d.state = uac_pkg::ST_OFF; // RULE10
      end
      default: begin
        s_d.state = uac_pkg::ST_IDLE;
      end
    endcase

    // Set wins over a same-cycle write-one-to-clear
    if (wrDone && avs_address == `UAC_OFF_IRQSTS) begin
      s_d.irqSts = s_q.irqSts & ~avs_writedata[`UAC_EV_W-1:0];
    end
    s_d.irqSts = s_d.irqSts | events;
    s_d.irq = |(s_d.irqSts & s_d.irqMsk);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.state <= uac_pkg::ST_IDLE;
      s_q.waitReq <= `UAC_RST_WAITREQ;
      s_q.irqMsk <= `UAC_RST_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitReq;
  assign coreReq = s_q.coreReq;
  assign submEntry = s_q.subm;
  assign irq = s_q.irq;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence sCmdIdle(logic [2:0] v);
    cmdWr && avs_writedata[2:0] == v && s_q.state == uac_pkg::ST_IDLE;
  endsequence

  sequence sDoneRun;
    s_q.state == uac_pkg::ST_RUN && !coreRsp.busy;
  endsequence

  sequence sShutDone;
    sDoneRun ##0 (s_q.coreReq.cmd == `UAC_CMD_SHUTDOWN && !s_q.err && !coreRsp.error);
  endsequence

  sequence sRdAt(logic [15:0] a);
    rdTake && avs_address == a;
  endsequence

  a_smart_issue: assert property ( // RULE1
    sCmdIdle(`UAC_CMD_SMART) |=> coreReq.req && coreReq.cmd == `UAC_CMD_SMART
  ) else $error("health-log request not issued");

  a_flush_issue: assert property ( // RULE2
    sCmdIdle(`UAC_CMD_FLUSH) |=> coreReq.req && coreReq.cmd == `UAC_CMD_FLUSH
  ) else $error("flush request not issued");

  a_shutdown_issue: assert property ( // RULE3
    sCmdIdle(`UAC_CMD_SHUTDOWN) |=> coreReq.req && coreReq.cmd == `UAC_CMD_SHUTDOWN
  ) else $error("shutdown request not issued");

  a_busy_rise: assert property ( // RULE4
    sCmdIdle(`UAC_CMD_FLUSH) or sCmdIdle(`UAC_CMD_SMART) |=> $rose(s_q.busy)
  ) else $error("busy did not rise on accept");

  a_busy_hold: assert property ( // RULE5
    s_q.state == uac_pkg::ST_RUN && coreRsp.busy |=> s_q.busy
  ) else $error("busy dropped while command runs");

  a_busy_clear: assert property ( // RULE5
    sDoneRun |=> !s_q.busy ##0 s_q.irqSts[`UAC_EV_DONE]
  ) else $error("busy not cleared on completion");

  a_error_flag: assert property ( // RULE6
    s_q.state == uac_pkg::ST_RUN && coreRsp.error && !s_q.err
      |=> s_q.err && s_q.errCause == $past(coreRsp.errType)
  ) else $error("error flag or cause not latched");

  a_ram_fill: assert property ( // RULE7
    ramWr.en |=> s_q.ram[$past(ramWr.idx)] == $past(ramWr.data)
  ) else $error("returned payload not stored");

  a_off_stays: assert property ( // RULE10
    s_q.state == uac_pkg::ST_OFF |=> s_q.state == uac_pkg::ST_OFF && !coreReq.req && !s_q.busy
  ) else $error("command accepted after shutdown");

  a_fail_capture: assert property ( // RULE12
    verifyFail.valid && !s_q.irqSts[`UAC_EV_VFAIL]
      |=> s_q.failAddr == $past(verifyFail.addr) && s_q.irqSts[`UAC_EV_VFAIL]
  ) else $error("first mismatch not captured");

  a_entry_write: assert property ( // RULE13
    wrDone && avs_address == `UAC_OFF_SUBM && avs_byteenable == 4'hF
      |=> submEntry[0] == $past(avs_writedata)
  ) else $error("entry word 0 not written");

  a_busy_ignore: assert property ( // RULE15
    cmdWr && s_q.busy |=> $stable(coreReq.cmd) && !$rose(coreReq.req)
  ) else $error("command taken while busy");

  a_shutdown_busy: assert property ( // RULE4
    sCmdIdle(`UAC_CMD_SHUTDOWN) |=> $rose(s_q.busy)
  ) else $error("busy did not rise on shutdown accept");

  a_busy_source: assert property ( // RULE4
    !s_q.busy && !(cmdWr && cmdOk && s_q.state == uac_pkg::ST_IDLE)
      |=> !s_q.busy
  ) else $error("busy rose without an accepted command");

  a_req_taken: assert property ( // RULE5
    s_q.state == uac_pkg::ST_ISSUE && coreRsp.busy && !coreRsp.error
      |=> !coreReq.req && s_q.busy && s_q.state == uac_pkg::ST_RUN
  ) else $error("request not released or busy lost");

  a_err_issue: assert property ( // RULE6
    s_q.state == uac_pkg::ST_ISSUE && coreRsp.error
      |=> s_q.err && !s_q.busy && s_q.errCause == $past(coreRsp.errType)
  ) else $error("refused command not flagged");

  a_cause_hold: assert property ( // RULE6
    s_q.state == uac_pkg::ST_RUN && s_q.err |=> s_q.err && $stable(s_q.errCause)
  ) else $error("first error cause overwritten");

  a_off_enter: assert property ( // RULE10
    sShutDone |=> s_q.state == uac_pkg::ST_OFF && !s_q.busy
  ) else $error("shutdown did not park the port");

  a_sts_read: assert property ( // RULE9
    sRdAt(`UAC_OFF_STS) |=> avs_readdata[1:0] == $past({s_q.err, s_q.busy})
  ) else $error("status read does not show busy and error");

  a_cause_read: assert property ( // RULE6
    sRdAt(`UAC_OFF_ERRTYPE) |=> avs_readdata == $past(s_q.errCause)
  ) else $error("error cause not readable");

  a_entry_ro: assert property ( // RULE13
    rdTake && inRange(avs_address, `UAC_OFF_SUBM, 16'h0040)
      |=> avs_readdata == 32'h0000_0000
  ) else $error("entry word read back");

  a_ram_read: assert property ( // RULE14
    rdTake && inRange(avs_address, `UAC_OFF_RAM, 16'h0200)
      |=> avs_readdata == $past(s_q.ram[ramIdx])
  ) else $error("data RAM word not readable");

  a_fail_hold: assert property ( // RULE12
    s_q.irqSts[`UAC_EV_VFAIL]
      |=> $stable(s_q.failAddr) && $stable(s_q.expWords) && $stable(s_q.readWords)
  ) else $error("first mismatch record overwritten");

  // One wait-free cycle per access keeps the master's hold window short
  a_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest
  ) else $error("waitrequest low for more than one cycle");

endmodule : uac_top

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "uac_cfg.svh"
module tb_top;
  typedef struct {logic wr; logic [15:0] a; logic [31:0] d;} uac_tb_row_t;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [15:0] avs_address = 16'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  uac_pkg::uac_core_req_t coreReq;
  logic [`UAC_SUBM_WORDS-1:0][31:0] submEntry;
  uac_pkg::uac_core_rsp_t coreRsp = '0;
  uac_pkg::uac_ram_wr_t ramWr = '0;
  uac_pkg::uac_fail_t verifyFail = '0;
  logic [31:0] linkStatus = 32'h0;
  logic irq;
  logic [31:0] rdq;
  int num_errors = 0;
  int comparisons = 0;
  // Mask and RAM word round trips, then reads past the stored words and writes to write-only or unmapped places
  uac_tb_row_t rows [10] = '{
    '{1'h1, `UAC_OFF_IRQMSK, 32'h7}, '{1'h0, `UAC_OFF_IRQMSK, 32'h7},
    '{1'h1, `UAC_OFF_RAM + 16'h4, 32'hAABBCCDD}, '{1'h0, `UAC_OFF_RAM + 16'h4, 32'hAABBCCDD},
    '{1'h1, 16'h4200, 32'h12345678}, '{1'h0, 16'h4200, 32'h0},
    '{1'h1, `UAC_OFF_SUBM + 16'h3C, 32'hCAFE000F}, '{1'h0, `UAC_OFF_SUBM + 16'h3C, 32'h0},
    '{1'h1, 16'h0FFC, 32'h5}, '{1'h0, 16'h0FFC, 32'h0}};

  always #2 ref_clk = ~ref_clk;

  uac_top u_uac_top (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .coreReq(coreReq), .submEntry(submEntry),
    .coreRsp(coreRsp), .ramWr(ramWr), .verifyFail(verifyFail), .linkStatus(linkStatus),
    .irq(irq));

  task automatic test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'h0);
    rdq = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : bus

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rdq, exp);
  endtask : rd

  // Bench plays the command core; e injects a failure mid-run
  task automatic cmd(input logic [2:0] c, input logic e);
    int n;
    for (int i = 0; i < 16; i++) wr(`UAC_OFF_SUBM + 16'(4 * i), {24'hE00000, 5'(i), c});
    tick(1);
    chk(submEntry[15], {24'hE00000, 5'h0F, c});
    wr(`UAC_OFF_CMD, {29'h0, c});
    n = 0;
    while (coreReq.req !== 1'h1 && n < 20) begin
      tick(1);
      n++;
    end
    chk({28'h0, coreReq}, {28'h0, 1'h1, c});
    rd(`UAC_OFF_STS, 32'h1);
    wr(`UAC_OFF_CMD, {29'h0, c ^ 3'h2});
    rd(`UAC_OFF_CMD, {29'h0, c});
    coreRsp.busy <= 1'h1;
    tick(3);
    chk({31'h0, coreReq.req}, 32'h0);
    if (c == `UAC_CMD_SMART) begin
      ramWr <= '{en: 1'h1, idx: 7'h03, data: 32'h5A5A0003};
      tick(1);
      ramWr.en <= 1'h0;
    end
    if (e) begin
      coreRsp.error <= 1'h1;
      coreRsp.errType <= 32'h00000BAD;
      tick(1);
      coreRsp.error <= 1'h0;
    end
    rd(`UAC_OFF_STS, {30'h0, e, 1'h1});
    coreRsp.busy <= 1'h0;
    n = 0;
    do begin
      bus(1'h0, `UAC_OFF_STS, 32'h0);
      n++;
    end while (rdq[0] !== 1'h0 && n < 20);
    chk(rdq, {30'h0, e, 1'h0});
    rd(`UAC_OFF_IRQSTS, {30'h0, e, 1'h1});
    chk({31'h0, irq}, 32'h1);
    wr(`UAC_OFF_IRQSTS, 32'h7);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    if (e) rd(`UAC_OFF_ERRTYPE, 32'h00000BAD);
    if (c == `UAC_CMD_SMART) rd(`UAC_OFF_RAM + 16'hC, 32'h5A5A0003);
  endtask : cmd

  initial begin
    tick(3);
    chk({31'h0, avs_waitrequest}, 32'h1);
    chk({28'h0, coreReq}, 32'h0);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].d);
    end
    chk(submEntry[15], 32'hCAFE000F);
    // Half-word write keeps the upper lanes of the stored word
    avs_byteenable <= 4'h3;
    wr(`UAC_OFF_RAM + 16'h4, 32'h11112222);
    avs_byteenable <= 4'hF;
    rd(`UAC_OFF_RAM + 16'h4, 32'hAABB2222);
    linkStatus <= 32'h00001234;
    tick(2);
    repeat (2) rd(`UAC_OFF_LINK, 32'h00001234);
    cmd(`UAC_CMD_SMART, 1'h0);
    cmd(`UAC_CMD_FLUSH, 1'h1);
    wr(`UAC_OFF_CMD, 32'h2);
    tick(3);
    chk({31'h0, coreReq.req}, 32'h0);
    rd(`UAC_OFF_CMD, {29'h0, `UAC_CMD_FLUSH});
    // Second mismatch must not overwrite the first one captured
    wr(`UAC_OFF_IRQMSK, 32'h3);
    verifyFail <= {1'h1, 57'h1ABCDEF89ABCDE0, 128'h33333333222222221111111100000000,
      128'h88888888777777776666666655555555};
    tick(1);
    verifyFail <= {1'h1, 57'h0, 128'h0, 128'h0};
    tick(1);
    verifyFail.valid <= 1'h0;
    tick(2);
    chk({31'h0, irq}, 32'h0);
    rd(`UAC_OFF_FAILL, 32'h89ABCDE0);
    rd(`UAC_OFF_FAILH, 32'h01ABCDEF);
    rd(`UAC_OFF_EXP + 16'h4, 32'h11111111);
    rd(`UAC_OFF_RDPAT + 16'hC, 32'h88888888);
    rd(`UAC_OFF_STS, 32'h6);
    wr(`UAC_OFF_IRQMSK, 32'h7);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    wr(`UAC_OFF_IRQSTS, 32'h4);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    // Core refuses at issue: the core never raises busy, error ends the command
    wr(`UAC_OFF_CMD, {29'h0, `UAC_CMD_FLUSH});
    coreRsp <= '{busy: 1'h0, error: 1'h1, errType: 32'h0000C0DE};
    tick(1);
    coreRsp.error <= 1'h0;
    rd(`UAC_OFF_STS, 32'h2);
    rd(`UAC_OFF_ERRTYPE, 32'h0000C0DE);
    chk({31'h0, irq}, 32'h1);
    wr(`UAC_OFF_IRQSTS, 32'h7);
    cmd(`UAC_CMD_SHUTDOWN, 1'h0);
    wr(`UAC_OFF_CMD, {29'h0, `UAC_CMD_SMART});
    tick(3);
    chk({31'h0, coreReq.req}, 32'h0);
    rd(`UAC_OFF_STS, 32'h0);
    rst_n <= 1'h0;
    tick(3);
    rst_n <= 1'h1;
    rd(`UAC_OFF_IRQMSK, 32'h0);
    test_done;
  end

  // Whole run needs under 400 cycles
  initial begin
    tick(20000);
    num_errors++;
    test_done;
  end
endmodule : tb_top
